// ---- common/irpsc_pkg.sv ----
package irpsc_pkg;

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int unsigned FIRST_CMD_CYCLES = 100;
    localparam int unsigned CNT_W            = 8;
    localparam int unsigned POR_CYCLES       = 16;
    localparam logic [CNT_W-1:0] CNT_ZERO    = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ONE     = 8'h01;

    // ---------------------------------------------------------------
    // Pin levels
    // ---------------------------------------------------------------
    localparam logic LVL_LOW  = 1'b0;
    localparam logic LVL_HIGH = 1'b1;

    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        IRPSC_RESET,
        IRPSC_DEFAULT,
        IRPSC_HARD_STBY,
        IRPSC_SOFT_STBY,
        IRPSC_ACTIVE
    } irpsc_mode_t;

    typedef struct packed {
        logic flashClk;
        logic flashDataOut;
        logic flashSelectN;
        logic sensorClockOut;
        logic sensorResetN;
    } irpsc_pins_t;

    typedef struct packed {
        irpsc_mode_t      mode;
        logic             porDone;
        logic [CNT_W-1:0] porCnt;
        logic [CNT_W-1:0] cmdCnt;
        logic             hostReady;
        logic             hardNSync1;
        logic             hardNSync2;
        logic             stbySync1;
        logic             stbySync2;
    } irpsc_state_t;

endpackage

// ---- rtl/irpsc_reset_pin_ctrl.sv ----
`timescale 1ns/1ps
// Summary of operation
// - An internal reset runs by itself after power comes up.
// - That power-on reset works whatever level the hard reset pin has.
// - A low pulse on the active-low hard reset pin is taken as hard reset.
// - A soft reset command from the host interface resets the device.
// - Sensor reset is low in reset and default, high in the standby states.
// - The flash data input pull-up stays enabled in every state.
// - Host data and sensor control clock and data are released, never driven high.
// - Flash pins float in reset and idle at clk low, data low, select high.
// - While hard reset is low the device stays in reset with flash pins floating and sensor clock and reset driven low.
// - Standby high puts the device in hard standby; low moves it on to soft standby.
module irpsc_reset_pin_ctrl #(
    parameter int unsigned FIRST_CMD = irpsc_pkg::FIRST_CMD_CYCLES
) (
    // Clock and power-on reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    // Pins from outside
    input  wire logic                 hardResetN,
    input  wire logic                 standbyIn,
    // Firmware side
    input  wire logic                 softResetCmd,
    input  wire logic                 fwRelease,
    input  wire logic                 fwSoftStandby,
    // Pin drive
    output irpsc_pkg::irpsc_pins_t    pinOut,
    output irpsc_pkg::irpsc_pins_t    pinOe,
    output logic                      flashDataInPullUp,
    output logic                      hostDataOe,
    output logic                      sensorCtrlClkOe,
    output logic                      sensorCtrlDataOe,
    // Status
    output irpsc_pkg::irpsc_mode_t    mode,
    output logic                      hostCmdReady,
    output logic                      coreResetActive
);

    irpsc_pkg::irpsc_state_t stateReg;
    irpsc_pkg::irpsc_state_t stateNext;
    logic                    inReset;

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        stateNext = stateReg;
        stateNext.hardNSync1 = hardResetN;
        stateNext.hardNSync2 = stateReg.hardNSync1;
        stateNext.stbySync1  = standbyIn;
        stateNext.stbySync2  = stateReg.stbySync1;
        // The counter ignores the reset pin, so either level at power-up works.
        if (!stateReg.porDone) begin
            stateNext.porCnt = stateReg.porCnt + irpsc_pkg::CNT_ONE;
            if (stateReg.porCnt ==
                irpsc_pkg::CNT_W'(irpsc_pkg::POR_CYCLES - 1)) begin
                stateNext.porDone = 1'b1;
            end
        end
        if (!stateReg.hardNSync2 || softResetCmd ||
            !stateReg.porDone) begin
            stateNext.mode      = irpsc_pkg::IRPSC_RESET;
            stateNext.cmdCnt    = irpsc_pkg::CNT_ZERO;
            stateNext.hostReady = 1'b0;
        end else begin
            // The wait counts from the synchronised release, so the host
            // gets two clocks of margin beyond the counted figure.
            if (!stateReg.hostReady) begin
                if (stateReg.cmdCnt == irpsc_pkg::CNT_W'(FIRST_CMD - 1)) begin
                    stateNext.hostReady = 1'b1;
                end else begin
                    stateNext.cmdCnt = stateReg.cmdCnt + irpsc_pkg::CNT_ONE;
                end
            end
            case (stateReg.mode)
                irpsc_pkg::IRPSC_RESET: begin
                    stateNext.mode = irpsc_pkg::IRPSC_DEFAULT;
                end
                default: begin
                    if (stateReg.stbySync2) begin
                        stateNext.mode = irpsc_pkg::IRPSC_HARD_STBY;
                    end else if (stateReg.mode ==
                                 irpsc_pkg::IRPSC_HARD_STBY) begin
                        stateNext.mode = irpsc_pkg::IRPSC_SOFT_STBY;
                    end else if (fwSoftStandby) begin
                        stateNext.mode = irpsc_pkg::IRPSC_SOFT_STBY;
                    end else if (fwRelease) begin
                        stateNext.mode = irpsc_pkg::IRPSC_ACTIVE;
                    end
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // State register
    // ---------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stateReg.mode       <= irpsc_pkg::IRPSC_RESET;
            stateReg.porDone    <= 1'b0;
            stateReg.porCnt     <= irpsc_pkg::CNT_ZERO;
            stateReg.cmdCnt     <= irpsc_pkg::CNT_ZERO;
            stateReg.hostReady  <= 1'b0;
            stateReg.hardNSync1 <= 1'b0;
            stateReg.hardNSync2 <= 1'b0;
            stateReg.stbySync1  <= 1'b0;
            stateReg.stbySync2  <= 1'b0;
        end else begin
            stateReg <= stateNext;
        end
    end

    // ---------------------------------------------------------------
    // Pin drive
    // ---------------------------------------------------------------
    assign inReset = (stateReg.mode == irpsc_pkg::IRPSC_RESET);

    always_comb begin
        pinOut.flashClk       = irpsc_pkg::LVL_LOW;
        pinOut.flashDataOut   = irpsc_pkg::LVL_LOW;
        pinOut.flashSelectN   = irpsc_pkg::LVL_HIGH;
        pinOut.sensorClockOut = irpsc_pkg::LVL_LOW;
        pinOut.sensorResetN   = irpsc_pkg::LVL_LOW;
        if (stateReg.mode != irpsc_pkg::IRPSC_RESET &&
            stateReg.mode != irpsc_pkg::IRPSC_DEFAULT) begin
            pinOut.sensorResetN = irpsc_pkg::LVL_HIGH;
        end
        // Flash pins float in reset; sensor clock and reset stay driven low.
        pinOe.flashClk       = !inReset;
        pinOe.flashDataOut   = !inReset;
        pinOe.flashSelectN   = !inReset;
        pinOe.sensorClockOut = 1'b1;
        pinOe.sensorResetN   = 1'b1;
    end

    // Open-drain lines are only released here; pull-ups set their level.
    assign hostDataOe        = 1'b0;
    assign sensorCtrlClkOe   = 1'b0;
    assign sensorCtrlDataOe  = 1'b0;
    assign flashDataInPullUp = 1'b1;
    assign mode              = stateReg.mode;
    assign hostCmdReady      = stateReg.hostReady;
    assign coreResetActive   = inReset;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    // Sensor clock levels are checked in every cycle, flash levels only out of reset; the sensor reset
    // level only in reset, default and hard standby, not in soft standby or active.
    sequence resetSeen;
        inReset;
    endsequence

    sequence readyWait;
        !stateReg.hostReady [*8];
    endsequence

    sequence hardHeld;
        !stateReg.hardNSync2 [*2];
    endsequence

    por_release_a: assert property (@(posedge clk) disable iff (rst)
        $rose(stateReg.porDone) && stateReg.hardNSync2 && !softResetCmd |=>
        !inReset)
        else $error("Power-on reset did not release.");
    por_pin_a: assert property (@(posedge clk) disable iff (rst)
        !stateReg.porDone |-> resetSeen)
        else $error("Left reset before power-on reset ended.");
    hard_reset_a: assert property (@(posedge clk) disable iff (rst)
        !stateReg.hardNSync2 |=> resetSeen)
        else $error("Hard reset not taken.");
    soft_reset_a: assert property (@(posedge clk) disable iff (rst)
        softResetCmd |=> inReset && !hostCmdReady)
        else $error("Soft reset not taken.");
    cmd_wait_a: assert property (@(posedge clk) disable iff (rst)
        $fell(inReset) |-> readyWait)
        else $error("Host ready too early.");
    sensor_reset_a: assert property (@(posedge clk) disable iff (rst)
        (mode == irpsc_pkg::IRPSC_HARD_STBY) |-> pinOut.sensorResetN)
        else $error("Sensor reset not released in standby.");
    flash_float_a: assert property (@(posedge clk) disable iff (rst)
        inReset |-> !pinOe.flashClk && !pinOe.flashDataOut &&
        !pinOe.flashSelectN)
        else $error("Flash pins driven in reset.");
    standby_entry_a: assert property (@(posedge clk) disable iff (rst)
        stateReg.stbySync2 && stateReg.hardNSync2 && !softResetCmd &&
        stateReg.porDone && !inReset |=>
        mode == irpsc_pkg::IRPSC_HARD_STBY)
        else $error("Standby not entered.");
    open_drain_a: assert property (@(posedge clk) disable iff (rst)
        !hostDataOe && !sensorCtrlClkOe && !sensorCtrlDataOe)
        else $error("Open-drain line driven.");
    pull_up_a: assert property (@(posedge clk) disable iff (rst)
        flashDataInPullUp)
        else $error("Flash data input pull-up off.");
    sensor_hold_a: assert property (@(posedge clk) disable iff (rst)
        (mode == irpsc_pkg::IRPSC_RESET || mode == irpsc_pkg::IRPSC_DEFAULT)
        |-> pinOe.sensorResetN && !pinOut.sensorResetN)
        else $error("Sensor reset not held low.");
    sensor_clock_a: assert property (@(posedge clk) disable iff (rst)
        pinOe.sensorClockOut && !pinOut.sensorClockOut)
        else $error("Sensor clock not driven low.");
    flash_idle_a: assert property (@(posedge clk) disable iff (rst)
        !inReset |-> pinOe.flashClk && pinOe.flashDataOut &&
        pinOe.flashSelectN && !pinOut.flashClk && !pinOut.flashDataOut &&
        pinOut.flashSelectN)
        else $error("Flash pins not at idle levels.");
    hard_hold_a: assert property (@(posedge clk) disable iff (rst)
        hardHeld |-> inReset && !pinOe.flashClk && !pinOe.flashDataOut &&
        !pinOe.flashSelectN)
        else $error("Left reset while hard reset held.");
    standby_exit_a: assert property (@(posedge clk) disable iff (rst)
        mode == irpsc_pkg::IRPSC_HARD_STBY && !stateReg.stbySync2 &&
        stateReg.hardNSync2 && !softResetCmd && stateReg.porDone |=>
        mode == irpsc_pkg::IRPSC_SOFT_STBY)
        else $error("Standby not left to soft standby.");

endmodule

// ---- verif/irpsc_far_model.sv ----
`timescale 1ns/1ps
// -----------------------------------------------
// Host and sensor side of the pins
// -----------------------------------------------
// Levels change only at the falling edge and are never left floating,
// so the synchronisers always see a clean level.
module irpsc_far_model (
    // Clock and host status
    input  wire logic clk,
    input  wire logic hostCmdReady,
    // Requests from the bench
    input  wire logic wantHard,
    input  wire logic wantStby,
    input  wire logic wantSoft,
    // Pins towards the device
    output logic      hardResetN,
    output logic      standbyIn,
    output logic      softResetCmd
);
    logic hardReq;
    logic stbyReq;
    logic softReq;
    initial begin
        hardResetN   = 1'b1;
        standbyIn    = 1'b0;
        softResetCmd = 1'b0;
        hardReq      = 1'b0;
        stbyReq      = 1'b0;
        softReq      = 1'b0;
    end
    // Requests are taken at the rising edge, so a bench change made at the
    // falling edge reaches the pins one whole cycle later, never in a race.
    always @(posedge clk) begin
        hardReq <= wantHard;
        stbyReq <= wantStby;
        softReq <= wantSoft;
    end
    always @(negedge clk) begin
        hardResetN <= !hardReq;
        standbyIn  <= stbyReq;
        // A command before the host wait has run out is held back.
        softResetCmd <= softReq && hostCmdReady && !softResetCmd;
    end
endmodule

// ---- verif/isp_reset_and_pin_state_control_test.sv ----
`timescale 1ns/1ps
module isp_reset_and_pin_state_control_test;
    localparam int unsigned FIRST = 12;
    logic clk = 1'b0, rst = 1'b1, fwRelease = 1'b0, fwSoftStandby = 1'b0;
    logic wantHard = 1'b1, wantStby = 1'b0, wantSoft = 1'b0;
    logic hardResetN, standbyIn, softResetCmd, pullUp, hostOe, sClkOe;
    logic sDatOe, hostCmdReady, coreResetActive;
    irpsc_pkg::irpsc_pins_t pinOut, pinOe;
    irpsc_pkg::irpsc_mode_t mode;
    int num_errors = 0, compares = 0, cycles = 0;
    irpsc_reset_pin_ctrl #(.FIRST_CMD(FIRST)) u_dut (.clk(clk), .rst(rst),
        .hardResetN(hardResetN), .standbyIn(standbyIn),
        .softResetCmd(softResetCmd), .fwRelease(fwRelease),
        .fwSoftStandby(fwSoftStandby), .pinOut(pinOut), .pinOe(pinOe),
        .flashDataInPullUp(pullUp), .hostDataOe(hostOe),
        .sensorCtrlClkOe(sClkOe), .sensorCtrlDataOe(sDatOe), .mode(mode),
        .hostCmdReady(hostCmdReady), .coreResetActive(coreResetActive));
    irpsc_far_model u_far (.clk(clk), .hostCmdReady(hostCmdReady),
        .wantHard(wantHard), .wantStby(wantStby), .wantSoft(wantSoft),
        .hardResetN(hardResetN), .standbyIn(standbyIn),
        .softResetCmd(softResetCmd));
    // The reference clock runs free for the whole run.
    initial forever #25 clk = !clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles > 3000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    task automatic chk(input string what, input logic [7:0] e, g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic waitMode(input irpsc_pkg::irpsc_mode_t m, input int lim);
        int n;
        n = 0;
        while (mode !== m && n < lim) begin
            @(negedge clk);
            n++;
        end
        chk("mode", {5'h00, m}, {5'h00, mode});
    endtask
    task automatic chkPins(input logic [4:0] eo, ee, mk);
        // Levels are compared only on pins that are expected to be driven.
        chk("pinOut", {3'h0, eo & ee & mk}, {3'h0, pinOut & ee & mk});
        chk("pinOe", {3'h0, ee & mk}, {3'h0, pinOe & mk});
    endtask
    task automatic t_por;
        repeat (12) @(negedge clk);
        chkPins(5'h00, 5'h03, 5'h1F);
        chk("quiet", 8'h08, {4'h0, pullUp, hostOe, sClkOe, sDatOe});
        rst = 1'b0;
        repeat (30) @(negedge clk);
        chk("mode", {5'h00, irpsc_pkg::IRPSC_RESET}, {5'h00, mode});
        wantHard = 1'b0;
        waitMode(irpsc_pkg::IRPSC_DEFAULT, 8);
        chkPins(5'h04, 5'h1F, 5'h1F);
        $display("test por done");
    endtask
    task automatic t_ready;
        int n;
        n = 0;
        chk("ready", 8'h00, {7'h00, hostCmdReady});
        while (hostCmdReady !== 1'b1 && n < FIRST + 4) begin
            @(negedge clk);
            n++;
        end
        chk("readyLate", 8'h01, {7'h00, n >= FIRST - 2});
        chk("ready", 8'h01, {7'h00, hostCmdReady});
        $display("test ready done");
    endtask
    task automatic t_hard;
        wantHard = 1'b1;
        fwRelease = 1'b1;
        waitMode(irpsc_pkg::IRPSC_RESET, 5);
        repeat (6) @(negedge clk);
        chk("mode", {5'h00, irpsc_pkg::IRPSC_RESET}, {5'h00, mode});
        chkPins(5'h00, 5'h00, 5'h1C);
        chk("coreResetActive", 8'h01, {7'h00, coreResetActive});
        wantHard = 1'b0;
        fwRelease = 1'b0;
        waitMode(irpsc_pkg::IRPSC_DEFAULT, 6);
        t_ready();
        $display("test hard done");
    endtask
    task automatic t_soft;
        wantSoft = 1'b1;
        @(negedge clk);
        wantSoft = 1'b0;
        waitMode(irpsc_pkg::IRPSC_RESET, 3);
        chkPins(5'h00, 5'h01, 5'h1D);
        waitMode(irpsc_pkg::IRPSC_DEFAULT, 4);
        t_ready();
        $display("test soft done");
    endtask
    task automatic t_stby;
        wantStby = 1'b1;
        waitMode(irpsc_pkg::IRPSC_HARD_STBY, 5);
        fwRelease = 1'b1;
        repeat (3) @(negedge clk);
        chk("mode", {5'h00, irpsc_pkg::IRPSC_HARD_STBY}, {5'h00, mode});
        chkPins(5'h05, 5'h1F, 5'h1F);
        wantStby = 1'b0;
        fwSoftStandby = 1'b1;
        waitMode(irpsc_pkg::IRPSC_SOFT_STBY, 5);
        repeat (3) @(negedge clk);
        chkPins(5'h05, 5'h1F, 5'h1F);
        fwSoftStandby = 1'b0;
        waitMode(irpsc_pkg::IRPSC_ACTIVE, 4);
        chk("sensorResetN", 8'h01, {7'h00, pinOut.sensorResetN});
        chk("coreResetActive", 8'h00, {7'h00, coreResetActive});
        chk("quiet", 8'h08, {4'h0, pullUp, hostOe, sClkOe, sDatOe});
        fwRelease = 1'b0;
        $display("test standby done");
    endtask
    task automatic tally_and_finish;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        t_por();
        t_ready();
        t_hard();
        t_soft();
        t_stby();
        tally_and_finish();
    end
endmodule
